/* File: inc/mpdo_pkg.sv */
// Shared constants and types for the motor PWM period and duty block
package mpdo_pkg;

  // Widths of the time base, duty values, postscaler and dead-time counter
  localparam int CNT_W = 15;
  localparam int DUTY_W = 16;
  localparam int POST_W = 4;
  localparam int DT_W = 6;
  localparam int NUM_GEN = 3;

  // Time base counting modes
  typedef enum logic [1:0] {
    MPDO_FREE = 2'h0,
    MPDO_SINGLE = 2'h1,
    MPDO_UPDN = 2'h2,
    MPDO_UPDN_DBL = 2'h3
  } mpdo_mode_t;

  // Values after reset and counter steps
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [CNT_W-1:0] PERIOD_RST = 15'h0000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
  localparam logic [POST_W-1:0] POST_RST = 4'h0;
  localparam logic [POST_W-1:0] POST_ONE = 4'h1;
  localparam logic [DT_W-1:0] DT_RST = 6'h00;
  localparam logic [DT_W-1:0] DT_ONE = 6'h01;

endpackage

/* File: hdl/mpdo_duty_reg.sv */
// Duty buffer and hidden active compare value for one generator
`timescale 1ns/100ps
module mpdo_duty_reg (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Software write
  input wire logic duty_wr,
  input wire logic [mpdo_pkg::DUTY_W-1:0] duty_wdata,
  // Load control
  input wire logic direct_load,
  input wire logic sync_load,
  // Stored values
  output logic [mpdo_pkg::DUTY_W-1:0] duty_buffer,
  output logic [mpdo_pkg::DUTY_W-1:0] duty_active
);
  import mpdo_pkg::*;

  // Software-visible buffer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_buffer <= DUTY_RST;
    end else if (duty_wr) begin
      duty_buffer <= duty_wdata;
    end
  end

  // Active value; a direct write beats a boundary load in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_active <= DUTY_RST;
    end else if (duty_wr && direct_load) begin
      duty_active <= duty_wdata;
    end else if (sync_load) begin
      duty_active <= duty_buffer;
    end
  end

endmodule

/* File: hdl/mpdo_pair_out.sv */
// Output pin pair: complementary with dead-time blanking, or independent
`timescale 1ns/100ps
module mpdo_pair_out (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Compare result and pair configuration
  input wire logic cmp_in,
  input wire logic pair_independent_sel,
  input wire logic [mpdo_pkg::DT_W-1:0] dead_time,
  // Pins
  output logic out_high,
  output logic out_low
);
  import mpdo_pkg::*;

  logic cmp_q;
  logic [DT_W-1:0] dt_cnt;
  logic cmp_edge;
  logic blank;

  // Edge of the compare output starts a dead-time window
  assign cmp_edge = cmp_in != cmp_q;
  assign blank = cmp_edge ? (dead_time != DT_RST) : (dt_cnt > DT_ONE);

  // Previous compare value for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= cmp_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dt_cnt <= DT_RST;
    end else if (pair_independent_sel) begin
      dt_cnt <= DT_RST;
    end else if (cmp_edge) begin
      dt_cnt <= dead_time;
    end else if (dt_cnt != DT_RST) begin
      dt_cnt <= dt_cnt - DT_ONE;
    end
  end

  // Pin drive; both low in reset so the switches start off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_high <= 1'b0;
      out_low <= 1'b0;
    end else if (pair_independent_sel) begin
      out_high <= cmp_in;
      out_low <= cmp_in;
    end else begin
      out_high <= cmp_in && !blank;
      out_low <= !cmp_in && !blank;
    end
  end

endmodule

/* File: hdl/mpdo_top.sv */
// Motor PWM time base, period and duty buffering and output generation
//
// How it works
// - Period match clears or reverses time base
// - Edge modes load period on wrap
// - Up/down modes load period at zero
// - Stopped time base copies period continuously
// - Free-running wrap raises postscaled event
// - Single-event wrap raises event, stops run
// - Up/down zero turnaround raises postscaled event
// - Double update: events at zero and match
// - Every event sets the sticky flag
// - Single-event pulse: start, duty end, stop
// - Edge-aligned: active at zero, off at duty
// - Zero duty off, over-period duty on
// - Center: on down-match, off up-match
// - Complementary pair never both active
// - Independent pair: no dead time, both pins follow compare
// - Edge modes load duty on wrap
// - Stopped time base: duty writes apply at once
// - Up/down loads duty at zero turnaround
// - Double update loads duty at zero, match
// - Immediate update applies writes at once
// - Immediate update lengthens, shortens or starts pulses
// - Duty upper bits compare, bit 0 halves
`timescale 1ns/100ps
module mpdo_top #(
  parameter int NUM_GEN = mpdo_pkg::NUM_GEN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Prescaled counting strobe and prescaler half-phase
  input wire logic count_tick,
  input wire logic half_phase,
  // Time base control
  input wire mpdo_pkg::mpdo_mode_t timebase_mode_sel,
  input wire logic [mpdo_pkg::POST_W-1:0] output_postscale_sel,
  input wire logic run_wr,
  input wire logic run_wdata,
  // Period buffer write
  input wire logic period_wr,
  input wire logic [mpdo_pkg::CNT_W-1:0] period_wdata,
  // Duty buffer writes, one strobe per generator, shared data
  input wire logic [NUM_GEN-1:0] duty_wr,
  input wire logic [mpdo_pkg::DUTY_W-1:0] duty_wdata,
  // Output configuration
  input wire logic immediate_update_en,
  input wire logic [NUM_GEN-1:0] pair_independent_sel,
  input wire logic [mpdo_pkg::DT_W-1:0] dead_time,
  // Event flag clear
  input wire logic pwm_event_flag_clr,
  // Time base status
  output logic timebase_run,
  output logic [mpdo_pkg::CNT_W-1:0] timebase_counter,
  output logic count_down_flag,
  output logic [mpdo_pkg::CNT_W-1:0] period_buffer,
  output logic pwm_event_flag,
  // Pins
  output logic [NUM_GEN-1:0] pwm_high,
  output logic [NUM_GEN-1:0] pwm_low
);
  import mpdo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [CNT_W-1:0] period_active;
  logic edge_mode;
  logic counting;
  logic period_match;
  logic wrap_ev;
  logic upzero_ev;
  logic upmatch_ev;
  logic sync_load;
  logic direct_load;
  logic post_in;
  logic post_hit;
  logic event_now;
  logic [POST_W-1:0] post_cnt;
  logic [NUM_GEN-1:0] cmp_state;
  logic [DUTY_W-1:0] duty_active [NUM_GEN];

  // Duty match at full or half count point
  function automatic logic duty_hit(input logic [CNT_W-1:0] cnt,
                                    input logic [DUTY_W-1:0] duty,
                                    input logic half);
    duty_hit = (cnt == duty[DUTY_W-1:1]) && (!duty[0] || half);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Time base boundary strobes

  assign edge_mode = !timebase_mode_sel[1];
  assign counting = timebase_run && count_tick;
  assign period_match = timebase_counter == period_active;
  // Edge modes: match seen on a tick, counter clears on this edge
  assign wrap_ev = counting && edge_mode && period_match;
  // Up/down: counter reaches zero and turns upward
  assign upzero_ev = counting && !edge_mode && count_down_flag &&
                     (timebase_counter <= CNT_ONE);
  // Up/down: period match while counting up, turns downward
  assign upmatch_ev = counting && !edge_mode && !count_down_flag && period_match;

  ////////////////////////////////////////////////////////////////////////////
  // Time base counter and direction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timebase_counter <= CNT_RST;
    end else if (counting) begin
      if (wrap_ev || upzero_ev) begin
        timebase_counter <= CNT_RST;
      end else if (upmatch_ev) begin
        // A zero period keeps the counter parked at zero
        if (timebase_counter != CNT_RST) begin
          timebase_counter <= timebase_counter - CNT_ONE;
        end
      end else if (!edge_mode && count_down_flag) begin
        timebase_counter <= timebase_counter - CNT_ONE;
      end else begin
        timebase_counter <= timebase_counter + CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_down_flag <= 1'b0;
    end else if (edge_mode) begin
      count_down_flag <= 1'b0;
    end else if (upmatch_ev) begin
      count_down_flag <= 1'b1;
    end else if (upzero_ev) begin
      count_down_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run bit: software write wins over the single-event stop

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timebase_run <= 1'b0;
    end else if (run_wr) begin
      timebase_run <= run_wdata;
    end else if (wrap_ev && timebase_mode_sel == MPDO_SINGLE) begin
      timebase_run <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period double buffer

  // Software-visible period buffer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      period_buffer <= PERIOD_RST;
    end else if (period_wr) begin
      period_buffer <= period_wdata;
    end
  end

  // Active period follows the buffer while stopped and changes only at boundaries while running, so a period never glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      period_active <= PERIOD_RST;
    end else if (!timebase_run) begin
      period_active <= period_buffer;
    end else if (wrap_ev) begin
      period_active <= period_buffer;
    end else if (upzero_ev) begin
      period_active <= period_buffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler and event flag

  assign post_in = (timebase_mode_sel == MPDO_FREE && wrap_ev) ||
                   (timebase_mode_sel == MPDO_UPDN && upzero_ev);
  assign post_hit = post_in && (post_cnt == output_postscale_sel);
  assign event_now = post_hit ||
                     (timebase_mode_sel == MPDO_SINGLE && wrap_ev) ||
                     (timebase_mode_sel == MPDO_UPDN_DBL && (upzero_ev || upmatch_ev));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= POST_RST;
    end else if (!timebase_run) begin
      post_cnt <= POST_RST;
    end else if (post_in) begin
      post_cnt <= post_hit ? POST_RST : post_cnt + POST_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_event_flag <= 1'b0;
    end else if (event_now) begin
      pwm_event_flag <= 1'b1;
    end else if (pwm_event_flag_clr) begin
      pwm_event_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty load timing shared by all generators

  assign sync_load = wrap_ev || upzero_ev ||
                     (timebase_mode_sel == MPDO_UPDN_DBL && upmatch_ev);
  assign direct_load = !timebase_run || immediate_update_en;

  ////////////////////////////////////////////////////////////////////////////
  // Generators: duty registers, compare output, pin pair

  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_ch
    logic [DUTY_W-1:0] duty_now;
    logic hit;
    logic next_cmp;

    assign duty_now = duty_active[g];
    assign hit = duty_hit(timebase_counter, duty_now, half_phase);

    mpdo_duty_reg u_duty (
      .mclk(mclk),
      .rst_n(rst_n),
      .duty_wr(duty_wr[g]),
      .duty_wdata(duty_wdata),
      .direct_load(direct_load),
      .sync_load(sync_load),
      .duty_buffer(),
      .duty_active(duty_active[g])
    );

    // Compare output next state, in priority order
    always_comb begin
      next_cmp = cmp_state[g];
      // The compare output lags the counter by one edge, so the stop is seen
      // through the cleared run bit; that keeps the last count of the pulse
      if (timebase_mode_sel == MPDO_SINGLE && !timebase_run) begin
        next_cmp = 1'b0;
      end else if (duty_now == DUTY_RST) begin
        next_cmp = 1'b0;
      end else if (duty_now[DUTY_W-1:1] > period_active) begin
        next_cmp = 1'b1;
      end else if (duty_wr[g] && immediate_update_en && timebase_run) begin
        // Lengthen, shorten or start; late low duty waits
        if (cmp_state[g] && duty_wdata[DUTY_W-1:1] <= timebase_counter) begin
          next_cmp = 1'b0;
        end else if (!cmp_state[g] && duty_wdata[DUTY_W-1:1] > timebase_counter) begin
          next_cmp = 1'b1;
        end
      end else if (edge_mode) begin
        if (hit) begin
          next_cmp = 1'b0;
        end else if (timebase_counter == CNT_RST) begin
          next_cmp = 1'b1;
        end
      end else if (hit) begin
        next_cmp = count_down_flag;
      end
    end

    // Registered compare output
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_state[g] <= 1'b0;
      end else begin
        cmp_state[g] <= next_cmp;
      end
    end

    mpdo_pair_out u_pair (
      .mclk(mclk),
      .rst_n(rst_n),
      .cmp_in(cmp_state[g]),
      .pair_independent_sel(pair_independent_sel[g]),
      .dead_time(dead_time),
      .out_high(pwm_high[g]),
      .out_low(pwm_low[g])
    );
  end

endmodule

/* File: bench/mpdo_bridge_model.sv */
// Model of the power switch legs hanging on the PWM pins
`timescale 1ns/100ps
module mpdo_bridge_model (
  // Clock, pins and pair modes
  input wire logic mclk,
  input wire logic [2:0] pwm_high,
  input wire logic [2:0] pwm_low,
  input wire logic [2:0] pair_independent_sel,
  // Count of cycles with a shorted leg
  output int shoot_count
);
  logic [2:0] sel_q = 3'h7;
  initial shoot_count = 0;
  // leg short check
  // Independent legs feed separate loads, so both on is legal there
  always @(posedge mclk) begin
    sel_q <= pair_independent_sel;
    if (|(pwm_high & pwm_low & ~pair_independent_sel & ~sel_q)) begin
      shoot_count <= shoot_count + 1;
    end
  end
endmodule

/* File: bench/mpdo_top_props.sv */
// Checker for the time base, event flag and pin pairs
`timescale 1ns/100ps
module mpdo_top_props #(
  parameter int NUM_GEN = 3
) (
  // Clock, reset and strobes
  input wire logic mclk, rst_n, count_tick, run_wr, run_wdata, period_wr,
  input wire logic pwm_event_flag_clr,
  // Levels
  input wire mpdo_pkg::mpdo_mode_t timebase_mode_sel,
  input wire logic [mpdo_pkg::CNT_W-1:0] period_wdata,
  input wire logic [NUM_GEN-1:0] pair_independent_sel,
  // Outputs
  input wire logic timebase_run, count_down_flag, pwm_event_flag,
  input wire logic [mpdo_pkg::CNT_W-1:0] timebase_counter, period_buffer,
  input wire logic [NUM_GEN-1:0] pwm_high, pwm_low
);
  import mpdo_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic step;
  // Counting edge
  assign step = timebase_run && count_tick;
  free_wrap_a: assert property (step && timebase_mode_sel == MPDO_FREE &&
    timebase_counter == period_buffer |=> timebase_counter == CNT_RST)
    else $error("free counter missed wrap");
  updn_turn_a: assert property (step && timebase_mode_sel[1] && !count_down_flag &&
    timebase_counter == period_buffer && timebase_counter != CNT_RST |=> count_down_flag)
    else $error("counter did not reverse");
  single_stop_a: assert property (step && timebase_mode_sel == MPDO_SINGLE && !run_wr &&
    timebase_counter == period_buffer |=> !timebase_run && timebase_counter == CNT_RST &&
    pwm_event_flag) else $error("single event did not stop");
  stop_hold_a: assert property (!timebase_run |=> $stable(timebase_counter))
    else $error("counter moved while stopped");
  run_write_a: assert property (run_wr |=> timebase_run == $past(run_wdata))
    else $error("run write lost");
  period_buf_a: assert property (period_wr |=> period_buffer == $past(period_wdata))
    else $error("period buffer not written");
  flag_hold_a: assert property (pwm_event_flag && !pwm_event_flag_clr |=> pwm_event_flag)
    else $error("event flag dropped");
  pair_excl_a: assert property ((pwm_high & pwm_low & ~pair_independent_sel &
    ~$past(pair_independent_sel)) == '0) else $error("complementary pins both on");
  indep_pins_a: assert property (((pwm_high ^ pwm_low) & pair_independent_sel &
    $past(pair_independent_sel)) == '0) else $error("independent pins differ");
endmodule
bind mpdo_top mpdo_top_props #(.NUM_GEN(NUM_GEN)) i_props (.mclk(mclk), .rst_n(rst_n),
  .count_tick(count_tick), .run_wr(run_wr), .run_wdata(run_wdata), .period_wr(period_wr),
  .pwm_event_flag_clr(pwm_event_flag_clr), .timebase_mode_sel(timebase_mode_sel),
  .period_wdata(period_wdata), .pair_independent_sel(pair_independent_sel),
  .timebase_run(timebase_run), .count_down_flag(count_down_flag),
  .pwm_event_flag(pwm_event_flag), .timebase_counter(timebase_counter),
  .period_buffer(period_buffer), .pwm_high(pwm_high), .pwm_low(pwm_low));

/* File: bench/test_motor_pwm_period_duty_output.sv */
// Self-checking bench for the motor PWM period, duty and output block
`timescale 1ns/100ps
module test_motor_pwm_period_duty_output;
  import mpdo_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, count_tick = 1'b1, half_phase = 1'b1;
  mpdo_mode_t timebase_mode_sel = MPDO_FREE;
  logic [POST_W-1:0] output_postscale_sel = POST_RST;
  logic run_wr = 1'b0, run_wdata = 1'b0, period_wr = 1'b0, immediate_update_en = 1'b0;
  logic [CNT_W-1:0] period_wdata = CNT_RST;
  logic [2:0] duty_wr = 3'h0, pair_independent_sel = 3'h7;
  logic [DUTY_W-1:0] duty_wdata = DUTY_RST;
  logic [DT_W-1:0] dead_time = DT_RST;
  logic pwm_event_flag_clr = 1'b0;
  logic timebase_run, count_down_flag, pwm_event_flag;
  logic [CNT_W-1:0] timebase_counter, period_buffer;
  logic [2:0] pwm_high, pwm_low;
  int err_total = 0, checks = 0, cyc = 0, shoot_count, ev;
  int h[3], l[3];
  mpdo_top #(.NUM_GEN(3)) i_dut (.mclk(mclk), .rst_n(rst_n), .count_tick(count_tick),
    .half_phase(half_phase), .timebase_mode_sel(timebase_mode_sel),
    .output_postscale_sel(output_postscale_sel), .run_wr(run_wr), .run_wdata(run_wdata),
    .period_wr(period_wr), .period_wdata(period_wdata), .duty_wr(duty_wr),
    .duty_wdata(duty_wdata), .immediate_update_en(immediate_update_en),
    .pair_independent_sel(pair_independent_sel), .dead_time(dead_time),
    .pwm_event_flag_clr(pwm_event_flag_clr), .timebase_run(timebase_run),
    .timebase_counter(timebase_counter), .count_down_flag(count_down_flag),
    .period_buffer(period_buffer), .pwm_event_flag(pwm_event_flag),
    .pwm_high(pwm_high), .pwm_low(pwm_low));
  mpdo_bridge_model i_legs (.mclk(mclk), .pwm_high(pwm_high), .pwm_low(pwm_low),
    .pair_independent_sel(pair_independent_sel), .shoot_count(shoot_count));
  // Clock and hang guard; the whole run needs well under 2000 cycles
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe; s is {run, period, duty gen 2..0}
  task automatic put(input logic [4:0] s, input logic [15:0] d);
    @(posedge mclk);
    {run_wr, period_wr, duty_wr} <= s;
    run_wdata <= d[0];
    period_wdata <= d[14:0];
    duty_wdata <= d;
    @(posedge mclk);
    {run_wr, period_wr, duty_wr} <= 5'h00;
  endtask
  // Settle with the flag held clear, then count pin highs, lows and events
  task automatic win(input int s, input int n);
    logic seen;
    seen = 1'b0;
    h = '{0, 0, 0};
    l = '{0, 0, 0};
    ev = 0;
    repeat (s) @(posedge mclk) pwm_event_flag_clr <= 1'b1;
    repeat (n) begin
      @(posedge mclk);
      pwm_event_flag_clr <= pwm_event_flag;
      #1;
      if (pwm_event_flag === 1'b1 && !seen) ev++;
      seen = (pwm_event_flag === 1'b1);
      for (int g = 0; g < 3; g++) begin
        h[g] += int'(pwm_high[g] === 1'b1);
        l[g] += int'(pwm_low[g] === 1'b1);
      end
    end
    @(posedge mclk) pwm_event_flag_clr <= 1'b0;
  endtask
  task automatic wait_cnt(input logic [CNT_W-1:0] k);
    do @(posedge mclk); while (timebase_counter !== k);
  endtask
  task automatic t_free();
    put(5'h08, 16'h4);
    put(5'h01, 16'h4);
    put(5'h04, 16'hC);
    put(5'h10, 16'h1);
    win(12, 20);
    chk(16'(h[0]), 16'h8);
    chk(16'(h[1] + l[1]), 16'h0);
    chk(16'(h[2]), 16'h14);
    chk(16'(ev), 16'h4);
    output_postscale_sel <= POST_ONE;
    win(12, 40);
    chk(16'(ev), 16'h4);
    // Odd duty ends only in the second half-phase; held low the edge never comes
    half_phase <= 1'b0;
    put(5'h01, 16'h5);
    win(12, 20);
    chk(16'(h[0]), 16'h14);
    half_phase <= 1'b1;
    win(12, 20);
    chk(16'(h[0]), 16'h8);
    put(5'h08, 16'h9);
    put(5'h01, 16'h6);
    win(12, 20);
    chk(16'(h[0]), 16'h6);
    chk(16'(h[2]), 16'hC);
    $display("free-running test done");
  endtask
  task automatic t_iue();
    immediate_update_en <= 1'b1;
    wait_cnt(15'h3);
    put(5'h01, 16'h10);
    wait_cnt(15'h8);
    #1 chk({15'h0, pwm_high[0]}, 16'h1);
    wait_cnt(15'h0);
    put(5'h01, 16'h2);
    wait_cnt(15'h5);
    #1 chk({15'h0, pwm_high[0]}, 16'h0);
    put(5'h01, 16'h6);
    wait_cnt(15'h9);
    #1 chk({15'h0, pwm_high[0]}, 16'h0);
    wait_cnt(15'h2);
    #1 chk({15'h0, pwm_high[0]}, 16'h1);
    immediate_update_en <= 1'b0;
    $display("immediate update test done");
  endtask
  task automatic t_comp();
    put(5'h01, 16'h8);
    pair_independent_sel <= 3'h6;
    dead_time <= 6'h02;
    win(12, 20);
    chk(16'(h[0]), 16'h4);
    chk(16'(l[0]), 16'h8);
    pair_independent_sel <= 3'h7;
    dead_time <= DT_RST;
    $display("complementary test done");
  endtask
  task automatic t_single();
    @(posedge mclk) timebase_mode_sel <= MPDO_SINGLE;
    while (timebase_run !== 1'b0) @(posedge mclk);
    put(5'h08, 16'h4);
    put(5'h01, 16'h4);
    win(12, 1);
    put(5'h10, 16'h1);
    win(0, 20);
    chk(16'(h[0]), 16'h2);
    chk(16'(h[2]), 16'h5);
    chk(16'(ev), 16'h1);
    chk({15'h0, timebase_run}, 16'h0);
    $display("single event test done");
  endtask
  task automatic t_updn();
    timebase_mode_sel <= MPDO_UPDN;
    put(5'h10, 16'h1);
    win(12, 16);
    chk(16'(h[0]), 16'h8);
    chk(16'(h[2]), 16'h10);
    chk(16'(ev), 16'h1);
    put(5'h01, 16'h0);
    win(12, 16);
    chk(16'(h[0]), 16'h0);
    timebase_mode_sel <= MPDO_UPDN_DBL;
    put(5'h01, 16'h4);
    win(12, 16);
    chk(16'(h[0]), 16'h8);
    chk(16'(ev), 16'h4);
    $display("up/down test done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk({pwm_high, pwm_low, timebase_run, pwm_event_flag}, 16'h0);
    t_free();
    t_iue();
    t_comp();
    t_single();
    t_updn();
    chk(16'(shoot_count), 16'h0);
    print_verdict();
  end
endmodule
